// ==== sle_pkg.sv ====
// package for the serial line extension block: register map, field positions,
// reset values, break lengths and the core-facing carrier structs.
// assumes an 8-bit register port and a receive/transmit core beside the block.
package sle_pkg;

  // register indices on the plain register port
  localparam logic [1:0] SLE_OFS_STATUS = 2'h0;
  localparam logic [1:0] SLE_OFS_CONTROL = 2'h1;

  // line_status_extra field positions
  localparam int SLE_ST_LIN_FLAG = 7;
  localparam int SLE_ST_EDGE_FLAG = 6;
  localparam int SLE_ST_RX_INV = 4;
  localparam int SLE_ST_IDLE_RPT = 3;
  localparam int SLE_ST_LONG_BRK = 2;
  localparam int SLE_ST_LIN_EN = 1;
  localparam int SLE_ST_BUSY = 0;

  // line_control_extra field positions
  localparam int SLE_CT_RX_NINTH = 7;
  localparam int SLE_CT_TX_NINTH = 6;
  localparam int SLE_CT_DIR = 5;
  localparam int SLE_CT_TX_INV = 4;
  localparam int SLE_CT_OR_IE = 3;
  localparam int SLE_CT_NF_IE = 2;
  localparam int SLE_CT_FE_IE = 1;
  localparam int SLE_CT_PF_IE = 0;

  // values after reset
  localparam logic [7:0] SLE_RST_STATUS = 8'h00;
  localparam logic [7:0] SLE_RST_CONTROL = 8'h00;

  // break lengths in bit times
  localparam logic [3:0] SLE_TX_BRK_SHORT = 4'hA;
  localparam logic [3:0] SLE_TX_BRK_LONG = 4'hD;
  localparam logic [3:0] SLE_RX_BRK_NORMAL = 4'hA;
  localparam logic [3:0] SLE_RX_BRK_LIN = 4'hB;

  // transmit break sequencer
  typedef enum logic [0:0] {SLE_TX_IDLE, SLE_TX_BREAK} sle_tx_state_t;

  // signals arriving from the receive/transmit core
  typedef struct packed {
    logic bit_tick;
    logic rx_pin;
    logic start_detect;
    logic idle_detect;
    logic rx_standby;
    logic rx_done;
    logic rx_stop_zero;
    logic rx_ninth;
    logic nine_bit;
    logic tx_break_req;
    logic tx_bit;
    logic tx_data_write;
    logic [7:0] tx_byte;
    logic data_read;
    logic loop_select;
    logic rx_source_select;
    logic overrun_flag;
    logic noise_flag;
    logic parity_error_flag;
  } sle_core_in_t;

  // signals returned to the core and the pins
  typedef struct packed {
    logic rx_line;
    logic idle_set;
    logic break_seen;
    logic rx_buffer_full;
    logic framing_error_flag;
    logic tx_load;
    logic [8:0] tx_word;
    logic tx_break_active;
    logic tx_break_done;
    logic tx_pin_out;
    logic tx_pin_oe;
    logic err_irq;
    logic status_irq;
  } sle_core_out_t;

endpackage : sle_pkg

// ==== sle_ext.sv ====
// serial line extension: break detect and generation, pin polarity, ninth
// bits, single-wire direction and error interrupt requests.
// assumes a core that gives one bit_tick per bit time and sync inputs.
//
// Summary of operation
// - lin break flag set on detect, w1c
// - edge flag on active rx edge, w1c
// - receive inversion flips every received element
// - standby idle sets flag only if enabled
// - tx break 10/11 or 13/14 bit times
// - framing detection ignores long break control
// - rx break threshold 10/11 or 11/12
// - lin detect blocks framing and buffer full
// - busy flag: set at start, clear idle
// - received ninth bit readable above byte
// - ninth tx bit loaded with byte, held
// - single-wire direction bit controls tx pin
// - transmit inversion flips tx output
// - overrun flag with enable requests interrupt
// - noise flag with enable requests interrupt
// - framing flag with enable requests interrupt
// - parity flag with enable requests interrupt
// - buffer full set on character transfer
`timescale 1ns/1ps
`default_nettype none

module sle_ext
  import sle_pkg::*;
#(
  parameter int ADDR_W = 2,
  parameter int BRK_CNT_W = 4
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output var logic [7:0] reg_rdata,
  // core side
  input wire sle_core_in_t core_in,
  output var sle_core_out_t core_out
);

  // elaboration checks
  if (ADDR_W < 1)
  begin : g_chk_addr
    $error("ADDR_W must be at least 1");
  end
  if (BRK_CNT_W < 4)
  begin : g_chk_cnt
    $error("BRK_CNT_W must hold a count of 14");
  end

  // register state
  logic [7:0] status_reg;
  logic [7:0] control_reg;
  logic rx_prev;
  logic [BRK_CNT_W-1:0] rx_zero_cnt;
  logic [BRK_CNT_W-1:0] tx_brk_cnt;
  sle_tx_state_t tx_state;

  // field views
  wire lin_flag = status_reg[SLE_ST_LIN_FLAG];
  wire edge_flag = status_reg[SLE_ST_EDGE_FLAG];
  wire rx_polarity_invert = status_reg[SLE_ST_RX_INV];
  wire standby_idle_report = status_reg[SLE_ST_IDLE_RPT];
  wire long_tx_break = status_reg[SLE_ST_LONG_BRK];
  wire lin_break_detect_enable = status_reg[SLE_ST_LIN_EN];
  wire receiver_busy_flag = status_reg[SLE_ST_BUSY];
  wire rx_ninth_bit = control_reg[SLE_CT_RX_NINTH];
  wire tx_ninth_bit = control_reg[SLE_CT_TX_NINTH];
  wire single_wire_pin_direction = control_reg[SLE_CT_DIR];
  wire tx_polarity_invert = control_reg[SLE_CT_TX_INV];

  // register port decode, shared by reads and writes
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [1:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction : hit

  wire wr_status = reg_wr && hit(reg_addr, SLE_OFS_STATUS);
  wire wr_control = reg_wr && hit(reg_addr, SLE_OFS_CONTROL);
  wire rd_status = reg_rd && hit(reg_addr, SLE_OFS_STATUS);
  wire rd_control = reg_rd && hit(reg_addr, SLE_OFS_CONTROL);

  // receive line after polarity; the break counter and rx_line see this level
  wire rx_level = core_in.rx_pin ^ rx_polarity_invert;
  // edges judged on the raw pin, so flipping the invert control is no edge
  wire edge_hit = rx_polarity_invert ? (!rx_prev && core_in.rx_pin) :
    (rx_prev && !core_in.rx_pin);

  // break threshold; framing logic never sees the long tx control
  wire [BRK_CNT_W-1:0] rx_brk_base = BRK_CNT_W'(lin_break_detect_enable ?
    SLE_RX_BRK_LIN : SLE_RX_BRK_NORMAL);
  wire [BRK_CNT_W-1:0] rx_brk_len = rx_brk_base + BRK_CNT_W'(core_in.nine_bit);
  wire [BRK_CNT_W-1:0] next_rx_zero_cnt = !rx_level ? ((rx_zero_cnt == rx_brk_len) ?
    rx_zero_cnt : rx_zero_cnt + BRK_CNT_W'(1)) : '0;
  // one pulse when the run of zeros first reaches the threshold
  wire brk_hit = core_in.bit_tick && !rx_level &&
    (next_rx_zero_cnt == rx_brk_len) && (rx_zero_cnt != rx_brk_len);

  // idle report in standby
  wire next_idle_set = core_in.idle_detect &&
    (!core_in.rx_standby || standby_idle_report);

  // receive transfer gating while lin detection runs
  wire rx_accept = core_in.rx_done && !lin_break_detect_enable;
  wire fe_hit = rx_accept && core_in.rx_stop_zero;

  // status flags: hardware set wins over software clear
  wire w1c_lin = wr_status && reg_wdata[SLE_ST_LIN_FLAG];
  wire w1c_edge = wr_status && reg_wdata[SLE_ST_EDGE_FLAG];
  wire next_lin_flag = (brk_hit && lin_break_detect_enable) || (lin_flag && !w1c_lin);
  wire next_edge_flag = edge_hit || (edge_flag && !w1c_edge);
  wire next_busy = core_in.start_detect ||
    (receiver_busy_flag && !core_in.idle_detect);

  // status register: flags, then writable controls, bit 5 reads zero
  wire [7:0] next_status = {next_lin_flag, next_edge_flag, 1'b0,
    wr_status ? reg_wdata[4:1] : status_reg[4:1], next_busy};

  // control register: ninth rx bit captured on transfer, read-only
  wire next_rx_ninth = (rx_accept && core_in.nine_bit) ? core_in.rx_ninth : rx_ninth_bit;
  wire [7:0] next_control = {next_rx_ninth,
    wr_control ? reg_wdata[6:0] : control_reg[6:0]};

  // receive buffer and framing flags; set wins over the data read clear
  wire next_rx_full = rx_accept ||
    (core_out.rx_buffer_full && !core_in.data_read);
  wire next_fe_flag = fe_hit ||
    (core_out.framing_error_flag && !core_in.data_read);

  // transmit break sequencer
  wire [BRK_CNT_W-1:0] tx_brk_base = BRK_CNT_W'(long_tx_break ?
    SLE_TX_BRK_LONG : SLE_TX_BRK_SHORT);
  wire [BRK_CNT_W-1:0] tx_brk_len = tx_brk_base + BRK_CNT_W'(core_in.nine_bit);
  wire tx_last_tick = (tx_state == SLE_TX_BREAK) && core_in.bit_tick &&
    (tx_brk_cnt == BRK_CNT_W'(1));
  sle_tx_state_t next_tx_state;
  logic [BRK_CNT_W-1:0] next_tx_brk_cnt;

  // sequencer next state
  always_comb
  begin
    next_tx_state = tx_state;
    next_tx_brk_cnt = tx_brk_cnt;
    case (tx_state)
      SLE_TX_IDLE:
      begin
        if (core_in.tx_break_req)
        begin
          next_tx_state = SLE_TX_BREAK;
          next_tx_brk_cnt = tx_brk_len;
        end
      end
      SLE_TX_BREAK:
      begin
        if (tx_last_tick)
        begin
          next_tx_state = SLE_TX_IDLE;
          next_tx_brk_cnt = '0;
        end
        else if (core_in.bit_tick)
        begin
          next_tx_brk_cnt = tx_brk_cnt - BRK_CNT_W'(1);
        end
      end
      default:
      begin
        next_tx_state = SLE_TX_IDLE;
        next_tx_brk_cnt = '0;
      end
    endcase
  end

  // pin outputs; break forces space before inversion
  wire tx_level = (next_tx_state == SLE_TX_BREAK) ? 1'b0 : core_in.tx_bit;
  wire next_tx_pin = tx_level ^ tx_polarity_invert;
  wire single_wire = core_in.loop_select && core_in.rx_source_select;
  wire next_tx_oe = !single_wire || single_wire_pin_direction;

  // error interrupt request; level, follows flag and enable
  wire [3:0] err_src = {core_in.overrun_flag, core_in.noise_flag,
    core_out.framing_error_flag, core_in.parity_error_flag};
  wire [3:0] err_en = control_reg[SLE_CT_OR_IE:SLE_CT_PF_IE];
  wire next_err_irq = |(err_src & err_en);
  wire next_status_irq = lin_flag || edge_flag;

  // read mux; unmapped reads return zero
  wire [7:0] next_rdata = rd_status ? status_reg : (rd_control ? control_reg : 8'h00);

  // register file and line state
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      status_reg <= SLE_RST_STATUS;
      control_reg <= SLE_RST_CONTROL;
      rx_prev <= 1'b1;
      rx_zero_cnt <= '0;
      tx_brk_cnt <= '0;
      tx_state <= SLE_TX_IDLE;
      reg_rdata <= 8'h00;
    end
    else
    begin
      status_reg <= next_status;
      control_reg <= next_control;
      rx_prev <= core_in.rx_pin;
      rx_zero_cnt <= core_in.bit_tick || rx_level ? next_rx_zero_cnt : rx_zero_cnt;
      tx_brk_cnt <= next_tx_brk_cnt;
      tx_state <= next_tx_state;
      reg_rdata <= next_rdata;
    end
  end

  // core-facing outputs, all from flops
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      core_out <= '0;
      core_out.rx_line <= 1'b1;
      core_out.tx_pin_out <= 1'b1;
      core_out.tx_pin_oe <= 1'b1;
    end
    else
    begin
      core_out.rx_line <= rx_level;
      core_out.idle_set <= next_idle_set;
      core_out.break_seen <= brk_hit;
      core_out.rx_buffer_full <= next_rx_full;
      core_out.framing_error_flag <= next_fe_flag;
      // nine-bit word taken with the byte; ninth bit stays as last written
      core_out.tx_load <= core_in.tx_data_write;
      core_out.tx_word <= core_in.tx_data_write ? {tx_ninth_bit, core_in.tx_byte} :
        core_out.tx_word;
      core_out.tx_break_active <= (next_tx_state == SLE_TX_BREAK);
      core_out.tx_break_done <= tx_last_tick;
      core_out.tx_pin_out <= next_tx_pin;
      core_out.tx_pin_oe <= next_tx_oe;
      core_out.err_irq <= next_err_irq;
      core_out.status_irq <= next_status_irq;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  property p_lin_set;
    brk_hit && lin_break_detect_enable |=> lin_flag;
  endproperty
  a_lin_set: assert property (p_lin_set)
    else $error("lin break flag not set on detect");

  property p_lin_hold;
    lin_flag && !w1c_lin |=> lin_flag;
  endproperty
  a_lin_hold: assert property (p_lin_hold)
    else $error("lin break flag lost without a clear");

  property p_edge_set;
    (rx_polarity_invert ? (!rx_prev && core_in.rx_pin) : (rx_prev && !core_in.rx_pin))
      |=> edge_flag;
  endproperty
  a_edge_set: assert property (p_edge_set)
    else $error("edge flag missed an active edge");

  property p_rx_inv;
    1'b1 |=> core_out.rx_line == ($past(core_in.rx_pin) ^ $past(rx_polarity_invert));
  endproperty
  a_rx_inv: assert property (p_rx_inv)
    else $error("receive line polarity wrong");

  property p_idle_block;
    core_in.idle_detect && core_in.rx_standby && !standby_idle_report |=> !core_out.idle_set;
  endproperty
  a_idle_block: assert property (p_idle_block)
    else $error("idle reported in standby while disabled");

  property p_tx_len;
    tx_state == SLE_TX_IDLE && core_in.tx_break_req |=>
      tx_brk_cnt == (long_tx_break ? 4'hD : 4'hA) + {3'h0, core_in.nine_bit};
  endproperty
  a_tx_len: assert property (p_tx_len)
    else $error("transmit break length wrong");

  property p_lin_gate;
    lin_break_detect_enable && !core_out.rx_buffer_full |=> !core_out.rx_buffer_full;
  endproperty
  a_lin_gate: assert property (p_lin_gate)
    else $error("buffer full set while lin detect on");

  property p_fe_gate;
    lin_break_detect_enable && !core_out.framing_error_flag |=> !core_out.framing_error_flag;
  endproperty
  a_fe_gate: assert property (p_fe_gate)
    else $error("framing flag set while lin detect on");

  property p_busy;
    core_in.start_detect ##1 (!core_in.idle_detect)[*2] |=> receiver_busy_flag;
  endproperty
  a_busy: assert property (p_busy)
    else $error("receiver busy flag not held");

  property p_busy_clr;
    core_in.idle_detect && !core_in.start_detect |=> !receiver_busy_flag;
  endproperty
  a_busy_clr: assert property (p_busy_clr)
    else $error("receiver busy flag not cleared on idle");

  property p_tx_word;
    core_in.tx_data_write |=> core_out.tx_load &&
      core_out.tx_word == {$past(tx_ninth_bit), $past(core_in.tx_byte)};
  endproperty
  a_tx_word: assert property (p_tx_word)
    else $error("nine-bit word not loaded");

  property p_dir;
    core_in.loop_select && core_in.rx_source_select && !single_wire_pin_direction
      |=> !core_out.tx_pin_oe;
  endproperty
  a_dir: assert property (p_dir)
    else $error("tx pin driven in single-wire input mode");

  property p_tx_inv;
    next_tx_state == SLE_TX_IDLE |=>
      core_out.tx_pin_out == ($past(core_in.tx_bit) ^ $past(tx_polarity_invert));
  endproperty
  a_tx_inv: assert property (p_tx_inv)
    else $error("tx output polarity wrong");

  property p_err_irq;
    (err_src & err_en) == 4'h0 |=> !core_out.err_irq;
  endproperty
  a_err_irq: assert property (p_err_irq)
    else $error("error interrupt without an enabled source");

  property p_err_irq_on;
    core_in.overrun_flag && err_en[3] |=> core_out.err_irq;
  endproperty
  a_err_irq_on: assert property (p_err_irq_on)
    else $error("overrun interrupt not requested");

  property p_fe_set;
    core_in.rx_done && core_in.rx_stop_zero && !lin_break_detect_enable
      |=> core_out.framing_error_flag;
  endproperty
  a_fe_set: assert property (p_fe_set)
    else $error("framing flag not set on a bad stop bit");

  property p_rx_full_set;
    core_in.rx_done && !lin_break_detect_enable |=> core_out.rx_buffer_full;
  endproperty
  a_rx_full_set: assert property (p_rx_full_set)
    else $error("buffer full not set on transfer");

  property p_rx_ninth;
    core_in.rx_done && core_in.nine_bit && !lin_break_detect_enable
      |=> rx_ninth_bit == $past(core_in.rx_ninth);
  endproperty
  a_rx_ninth: assert property (p_rx_ninth)
    else $error("received ninth bit not captured");

  property p_status_irq;
    lin_flag || edge_flag |=> core_out.status_irq;
  endproperty
  a_status_irq: assert property (p_status_irq)
    else $error("status interrupt not requested");

endmodule : sle_ext

`default_nettype wire

// ==== sle_node_model.sv ====
// remote serial node model: drives the far end of the receive line.
// assumes a bit tick from the bench and a line that idles at mark.
`timescale 1ns/1ps
`default_nettype none

module sle_node_model
(
  // clock and bit timing
  input wire logic clk_sys,
  input wire logic tick,
  // line polarity and pin
  input wire logic invert,
  output wire logic pin
);
  logic lvl = 1'b1;

  // mark when idle; an inverted link idles low, like the real node
  assign pin = lvl ^ invert;

  // zero run of n bit times, started on a tick so the count stays whole
  task automatic send_zeros(input int n);
    @(posedge clk_sys iff tick);
    lvl <= 1'b0;
    repeat (n) @(posedge clk_sys iff tick);
    lvl <= 1'b1;
  endtask : send_zeros
endmodule : sle_node_model

`default_nettype wire

// ==== sle_ext_test.sv ====
// self-checking bench for the serial line extension block.
// assumes sle_pkg and a remote node model on the receive pin.
`timescale 1ns/1ps
`default_nettype none

module sle_ext_test
  import sle_pkg::*;
;
  logic clk_sys, rst_b, reg_wr, reg_rd, node_inv;
  logic rd_d = 1'b0;
  logic [1:0] reg_addr;
  logic [1:0] div = 2'h0;
  logic [7:0] reg_wdata, reg_rdata, b;
  logic [8:0] exp_q[$];
  sle_core_in_t ci, ci_w, m;
  sle_core_out_t co;
  wire logic node_pin;
  wire logic tick = (div == 2'h0);
  int error_cnt, total_checks, brk_cnt, idle_cnt, tx_ticks, n0, n;

  sle_ext sle_ext_i (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .core_in(ci_w), .core_out(co));
  sle_node_model sle_node_model_i (.clk_sys(clk_sys), .tick(tick), .invert(node_inv),
    .pin(node_pin));

  // bit tick every fourth cycle keeps break runs short
  always_comb
  begin
    ci_w = ci;
    ci_w.bit_tick = tick;
    ci_w.rx_pin = node_pin;
  end

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask : chk

  // watcher: pulse counts and read data against the oldest note
  always @(posedge clk_sys)
  begin
    div <= div + 2'h1;
    rd_d <= reg_rd;
    if (co.break_seen) brk_cnt++;
    if (co.idle_set) idle_cnt++;
    if (co.tx_break_active && tick) tx_ticks++;
    if (rd_d) chk("reg_rdata", exp_q.pop_front(), {1'b0, reg_rdata});
  end

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back({1'b0, e});
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask : rd

  // one-cycle pulse of the fields set in p, outputs settled on return
  task automatic pulse(input sle_core_in_t p);
    @(posedge clk_sys);
    ci <= ci | p;
    @(posedge clk_sys);
    ci <= ci & ~p;
    #1;
  endtask : pulse

  task automatic waitc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : waitc

  task automatic close_out;
    waitc(3);
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  initial
  begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    ci = '0;
    ci.tx_bit = 1'b1;
    node_inv = 1'b0;
    void'($urandom(32'h99a3));
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    // reset values, read-only bits, unmapped index
    rd(SLE_OFS_STATUS, SLE_RST_STATUS);
    rd(SLE_OFS_CONTROL, SLE_RST_CONTROL);
    wr(2'h2, 8'hFF);
    rd(2'h2, 8'h00);
    wr(SLE_OFS_STATUS, 8'h2F);
    rd(SLE_OFS_STATUS, 8'h0E);
    b = 8'($urandom);
    wr(SLE_OFS_CONTROL, b);
    rd(SLE_OFS_CONTROL, b & 8'h7F);
    wr(SLE_OFS_CONTROL, 8'h00);
    $display("registers done");
    // receive break thresholds; i[1] lin detect with inverted line, i[0] nine-bit
    for (int i = 0; i < 4; i++)
    begin
      ci.nine_bit <= i[0];
      node_inv <= i[1];
      wr(SLE_OFS_STATUS, {3'h0, i[1], 2'h0, i[1], 1'b0});
      wr(SLE_OFS_STATUS, {3'h6, i[1], 2'h0, i[1], 1'b0});
      n = 10 + i[0] + i[1];
      n0 = brk_cnt;
      sle_node_model_i.send_zeros(n - 1);
      sle_node_model_i.send_zeros(n);
      waitc(8);
      chk("break_seen", 9'h001, 9'(brk_cnt - n0));
      chk("rx_line", 9'h001, {8'h00, co.rx_line});
      rd(SLE_OFS_STATUS, {i[1], 2'h2, i[1], 2'h0, i[1], 1'b0});
      waitc(2);
      chk("status_irq", 9'h001, {8'h00, co.status_irq});
    end
    wr(SLE_OFS_STATUS, 8'hC0);
    node_inv <= 1'b0;
    $display("break detect done");
    // transmit break length; i[1] long break with inverted output
    for (int i = 0; i < 4; i++)
    begin
      ci.nine_bit <= i[0];
      wr(SLE_OFS_STATUS, {5'h0, i[1], 2'h0});
      wr(SLE_OFS_CONTROL, {3'h0, i[1], 4'h0});
      waitc(2);
      chk("tx_idle", {8'h00, ~i[1]}, {8'h00, co.tx_pin_out});
      m = '0;
      m.tx_break_req = 1'b1;
      pulse(m);
      n0 = tx_ticks;
      chk("tx_brk_pin", {8'h00, i[1]}, {8'h00, co.tx_pin_out});
      n = 0;
      while (co.tx_break_done !== 1'b1 && n < 400)
      begin
        waitc(1);
        n++;
      end
      if (n == 400)
      begin
        $display("[ERR] tx_break_done expected 1 seen 0");
        error_cnt++;
        close_out();
      end
      chk("brk_len", 9'(10 + 3 * i[1] + i[0]), 9'(tx_ticks - n0));
    end
    $display("tx break done");
    // single-wire direction
    ci.loop_select <= 1'b1;
    ci.rx_source_select <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      wr(SLE_OFS_CONTROL, {2'h0, i[0], 5'h00});
      waitc(2);
      chk("tx_pin_oe", {8'h00, i[0]}, {8'h00, co.tx_pin_oe});
    end
    wr(SLE_OFS_CONTROL, 8'h00);
    ci.loop_select <= 1'b0;
    waitc(3);
    chk("tx_pin_oe", 9'h001, {8'h00, co.tx_pin_oe});
    // ninth transmit bit written first, then held across bytes
    wr(SLE_OFS_CONTROL, 8'h40);
    ci.tx_byte <= b;
    m = '0;
    m.tx_data_write = 1'b1;
    pulse(m);
    chk("tx_load", 9'h001, {8'h00, co.tx_load});
    chk("tx_word", {1'b1, b}, co.tx_word);
    ci.tx_byte <= ~b;
    pulse(m);
    chk("tx_word", {1'b1, ~b}, co.tx_word);
    $display("tx ninth done");
    // lin detect blocks buffer full and framing; then a normal capture
    ci.rx_ninth <= 1'b1;
    ci.rx_stop_zero <= 1'b1;
    wr(SLE_OFS_STATUS, 8'h02);
    wr(SLE_OFS_CONTROL, 8'h02);
    m = '0;
    m.rx_done = 1'b1;
    pulse(m);
    chk("rx_full", 9'h000, {8'h00, co.rx_buffer_full});
    chk("framing", 9'h000, {8'h00, co.framing_error_flag});
    rd(SLE_OFS_CONTROL, 8'h02);
    // long transmit break left on: framing must not care
    wr(SLE_OFS_STATUS, 8'h04);
    pulse(m);
    chk("rx_full", 9'h001, {8'h00, co.rx_buffer_full});
    chk("framing", 9'h001, {8'h00, co.framing_error_flag});
    waitc(2);
    chk("err_irq", 9'h001, {8'h00, co.err_irq});
    rd(SLE_OFS_CONTROL, 8'h82);
    m = '0;
    m.data_read = 1'b1;
    pulse(m);
    waitc(2);
    chk("rx_full", 9'h000, {8'h00, co.rx_buffer_full});
    chk("err_irq", 9'h000, {8'h00, co.err_irq});
    // error flags from the core against their enables
    for (int i = 0; i < 3; i++)
    begin
      ci.overrun_flag <= (i == 0);
      ci.noise_flag <= (i == 1);
      ci.parity_error_flag <= (i == 2);
      wr(SLE_OFS_CONTROL, 8'h00);
      waitc(2);
      chk("err_irq", 9'h000, {8'h00, co.err_irq});
      wr(SLE_OFS_CONTROL, (i == 0) ? 8'h08 : (i == 1) ? 8'h04 : 8'h01);
      waitc(2);
      chk("err_irq", 9'h001, {8'h00, co.err_irq});
    end
    $display("rx flags and irq done");
    // standby idle report, then receiver busy
    ci.rx_standby <= 1'b1;
    m = '0;
    m.idle_detect = 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      wr(SLE_OFS_STATUS, {4'h0, i[0], 3'h0});
      n0 = idle_cnt;
      pulse(m);
      waitc(2);
      chk("idle_set", 9'(i), 9'(idle_cnt - n0));
    end
    m = '0;
    m.start_detect = 1'b1;
    pulse(m);
    rd(SLE_OFS_STATUS, 8'h09);
    m = '0;
    m.idle_detect = 1'b1;
    pulse(m);
    rd(SLE_OFS_STATUS, 8'h08);
    $display("standby and busy done");
    close_out();
  end
endmodule : sle_ext_test

`default_nettype wire
